/* rtl/request_node_pkg.sv */
// package: register layout, reset values and arbitration codes for the request node
package request_node_pkg;
   // ==========================================================
   // register map
   localparam logic [11:0] REQUEST_CONTROL_OFFSET = 12'h000;
   localparam int          NODE_COUNT             = 5;      // nodes 0..3 free of sources, node 4 has a source
   localparam int          SOURCE_NODE            = 4;
   localparam int          NODE_STRIDE            = 4;

   // ==========================================================
   // field positions of request_control
   localparam int SET_BIT       = 15;
   localparam int CLEAR_BIT     = 14;
   localparam int PENDING_BIT   = 13;
   localparam int ENABLE_BIT    = 12;
   localparam int SELECT_HI     = 11;
   localparam int SELECT_LO     = 10;
   localparam int PRIORITY_HI   = 7;
   localparam int PRIORITY_LO   = 0;

   // ==========================================================
   // reset values, no-priority code and provider count
   localparam logic       PENDING_RESET  = 1'b0;
   localparam logic       ENABLE_RESET   = 1'b0;
   localparam logic [1:0] SELECT_RESET   = 2'b00;
   localparam logic [7:0] PRIORITY_RESET = 8'h00;
   localparam logic [7:0] PRIORITY_NONE  = 8'h00;
   localparam int         PROVIDER_COUNT = 4;

   // ==========================================================
   // arbitration round phases seen by a node
   typedef enum logic [0:0] {
      ROUND_IDLE = 1'b0,
      ROUND_BUSY = 1'b1
   } round_phase_t;
endpackage : request_node_pkg

/* rtl/node_slice.sv */
// file: one request node slice holding flag, enable, selector and priority
`timescale 1ns/10ps
module node_slice (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       wr_hit,
   input  wire logic [31:0] wr_data,
   input  wire logic       rmw_write,
   input  wire logic       hw_trigger,
   input  wire logic       hw_ack,
   input  wire logic       round_busy,
   output logic [31:0]     read_word,
   output logic [3:0]      request_lines,
   output logic [7:0]      request_priority
);
   import request_node_pkg::*;

   typedef struct packed {
      logic       pending_flag;
      logic       node_enable;
      logic [1:0] provider_select;
      logic [7:0] node_priority;
      logic       eligible;        // pending caught outside a round
   } slice_state_t;

   slice_state_t state_r;
   slice_state_t state_nxt;
   logic         sw_set;
   logic         sw_clear;

   // ==========================================================
   // next state
   always_comb begin
      state_nxt = state_r;
      sw_set    = wr_hit && wr_data[SET_BIT] && !wr_data[CLEAR_BIT];
      sw_clear  = wr_hit && wr_data[CLEAR_BIT] && !wr_data[SET_BIT];
      // hardware update, regardless of enable; a fresh trigger beats a coinciding acknowledge
      if (hw_ack) begin
         state_nxt.pending_flag = 1'b0;
      end
      if (hw_trigger) begin
         state_nxt.pending_flag = 1'b1;
      end
      // software write wins over a coinciding hardware update
      if (wr_hit && rmw_write) begin
         state_nxt.pending_flag = state_r.pending_flag;
      end
      if (sw_set) begin
         state_nxt.pending_flag = 1'b1;
      end else if (sw_clear) begin
         state_nxt.pending_flag = 1'b0;
      end
      // direct pending writes ignored; only config fields stored
      if (wr_hit) begin
         state_nxt.node_enable     = wr_data[ENABLE_BIT];
         state_nxt.provider_select = wr_data[SELECT_HI:SELECT_LO];
         state_nxt.node_priority   = wr_data[PRIORITY_HI:PRIORITY_LO];
      end
      // a newly pending request joins only once no round is running
      if (!state_nxt.pending_flag) begin
         state_nxt.eligible = 1'b0;
      end else if (!round_busy) begin
         state_nxt.eligible = 1'b1;
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r <= '{PENDING_RESET, ENABLE_RESET, SELECT_RESET, PRIORITY_RESET, 1'b0};
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // read view and arbitration request
   always_comb begin
      read_word = 32'h0000_0000;
      read_word[PENDING_BIT]             = state_r.pending_flag;
      read_word[ENABLE_BIT]              = state_r.node_enable;
      read_word[SELECT_HI:SELECT_LO]     = state_r.provider_select;
      read_word[PRIORITY_HI:PRIORITY_LO] = state_r.node_priority;
      request_lines    = 4'h0;
      request_priority = state_r.node_priority;
      if (state_r.eligible && state_r.pending_flag && state_r.node_enable
          && state_r.node_priority != PRIORITY_NONE) begin
         request_lines[state_r.provider_select] = 1'b1;
      end
   end
endmodule : node_slice

/* rtl/request_node.sv */
// file: top of the request node group with apb slave and arbitration bus
`timescale 1ns/10ps
// What this block does
// - set bit write sets pending flag
// - clear bit write clears pending flag
// - both bits together leave flag unchanged
// - set and clear bits store nothing
// - software write beats coinciding hardware update
// - source trigger sets, acknowledge clears flag
// - direct writes to pending flag ignored
// - flag works regardless of enable bit
// - enabled pending node joins selected arbitration
// - disabled node never requests; software clears
// - keeps requesting until cleared or accepted
// - selector routes to provider zero to three
// - priority ranks request; zero never serviced
// - compared priority subrange must stay unique
// - up to 255 active nodes per provider
// - priority number selects vector entry
// - four nodes set only by writes
// - acknowledge from controller clears winner flag
// - new request waits for running round
module request_node #(
   parameter int PRIO_BITS = 8
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   input  wire logic                 source_trigger,
   input  wire logic                 rmw_lock,
   input  wire logic [3:0]           round_active,
   input  wire logic [3:0]           ack_valid,
   input  wire logic [7:0]           ack_priority,
   output logic [3:0]                provider_request,
   output logic [3:0][7:0]           provider_winner
);
   import request_node_pkg::*;

   typedef struct packed {
      logic                  ready;
      logic [31:0]           rdata;
      logic                  slverr;
      logic [3:0]            request;
      logic [3:0][7:0]       winner;
   } top_state_t;

   top_state_t                     state_r;
   top_state_t                     state_nxt;
   logic [NODE_COUNT-1:0]          node_hit;
   logic [NODE_COUNT-1:0][31:0]    node_word;
   logic [NODE_COUNT-1:0][3:0]     node_lines;
   logic [NODE_COUNT-1:0][7:0]     node_prio;
   logic [NODE_COUNT-1:0]          node_ack;
   logic [NODE_COUNT-1:0]          node_busy;
   logic                           access_cycle;
   logic                           write_cycle;
   logic                           addr_ok;
   logic [2:0]                     node_index;

   // ==========================================================
   // apb decode, one aligned word per node
   assign access_cycle = psel && penable && !state_r.ready;
   // writes land only at the edge that samples pready high
   assign write_cycle  = psel && penable && state_r.ready && pwrite;
   assign node_index   = paddr[4:2];
   assign addr_ok      = (paddr[1:0] == 2'b00) && (paddr[11:5] == 7'h00)
                         && (int'(node_index) < NODE_COUNT);

   // ==========================================================
   // per node slices
   genvar gi;
   generate
      for (gi = 0; gi < NODE_COUNT; gi++) begin : g_node
         always_comb begin
            node_hit[gi]  = write_cycle && addr_ok && (int'(node_index) == gi);
            node_busy[gi] = round_active[node_word[gi][SELECT_HI:SELECT_LO]];
            // only the round winner at this provider takes the acknowledge
            node_ack[gi]  = ack_valid[node_word[gi][SELECT_HI:SELECT_LO]]
                            && node_word[gi][ENABLE_BIT] && node_word[gi][PENDING_BIT]
                            && (node_prio[gi][PRIO_BITS-1:0] == ack_priority[PRIO_BITS-1:0]);
         end
         node_slice u_slice (
            .clk_sys          (clk_sys),
            .rst              (rst),
            .wr_hit           (node_hit[gi]),
            .wr_data          (pwdata),
            .rmw_write        (rmw_lock),
            .hw_trigger       ((gi == SOURCE_NODE) ? source_trigger : 1'b0),
            .hw_ack           (node_ack[gi]),
            .round_busy       (node_busy[gi]),
            .read_word        (node_word[gi]),
            .request_lines    (node_lines[gi]),
            .request_priority (node_prio[gi])
         );
      end
   endgenerate

   // ==========================================================
   // next state: apb answer and per provider maximum priority
   always_comb begin
      state_nxt        = state_r;
      state_nxt.ready  = access_cycle;
      state_nxt.slverr = access_cycle && !addr_ok;
      state_nxt.rdata  = 32'h0000_0000;
      if (access_cycle && !pwrite && addr_ok) begin
         state_nxt.rdata = node_word[node_index];
      end
      // highest eligible priority per provider, any count of nodes
      for (int p = 0; p < PROVIDER_COUNT; p++) begin
         state_nxt.request[p] = 1'b0;
         state_nxt.winner[p]  = PRIORITY_NONE;
         for (int n = 0; n < NODE_COUNT; n++) begin
            if (node_lines[n][p] && node_prio[n] > state_nxt.winner[p]) begin
               state_nxt.request[p] = 1'b1;
               state_nxt.winner[p]  = node_prio[n];
            end
         end
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // outputs straight from flops
   assign pready           = state_r.ready;
   assign prdata           = state_r.rdata;
   assign pslverr          = state_r.slverr;
   assign provider_request = state_r.request;
   assign provider_winner  = state_r.winner;
endmodule : request_node

/* bench/request_node_chk.sv */
// file: port checker for the request node group
`timescale 1ns/10ps
module request_node_chk #(
   parameter int PRIO_BITS = 8
) (
   input wire logic                 clk_sys,
   input wire logic                 rst,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          pwdata,
   input wire logic                 pready,
   input wire logic [31:0]          prdata,
   input wire logic                 pslverr,
   input wire logic                 source_trigger,
   input wire logic                 rmw_lock,
   input wire logic [3:0]           round_active,
   input wire logic [3:0]           ack_valid,
   input wire logic [7:0]           ack_priority,
   input wire logic [3:0]           provider_request,
   input wire logic [3:0][7:0]      provider_winner
);
   logic [7:0] acked_r;
   // ==========================================
   // last priority acknowledged on provider zero
   always_ff @(posedge clk_sys) begin
      if (ack_valid[0]) acked_r <= ack_priority;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // access phase still waiting for its answer
   sequence s_access;
      psel && penable && !pready;
   endsequence
   a_answer_next: assert property (s_access |=> pready) else $error("access not answered");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   a_idle_data: assert property (!pready |-> prdata == 32'h0000_0000) else $error("data outside answer");
   a_strobes_zero: assert property (pready |-> prdata[15:14] == 2'b00) else $error("strobe bits read back");
   a_reserved_zero: assert property (pready |-> prdata[31:16] == 16'h0000 && prdata[9:8] == 2'b00)
      else $error("reserved bits not zero");
   a_unmapped_err: assert property (s_access ##0 (paddr[11:2] > 10'h004) |=> pslverr) else $error("no error");
   a_winner_match: assert property (provider_request == {|provider_winner[3], |provider_winner[2],
      |provider_winner[1], |provider_winner[0]}) else $error("request and winner disagree");
   a_round_waits: assert property ((provider_request & ~$past(provider_request) & $past(round_active)
      & $past(round_active, 2)) == 4'h0) else $error("request joined a running round");
   a_ack_clears: assert property (ack_valid[0] && ack_priority == provider_winner[0]
      |=> ##[0:3] provider_winner[0] != acked_r) else $error("acknowledged node still wins");
endmodule : request_node_chk
bind request_node request_node_chk #(.PRIO_BITS(PRIO_BITS)) chk (.clk_sys(clk_sys), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .source_trigger(source_trigger), .rmw_lock(rmw_lock), .round_active(round_active),
   .ack_valid(ack_valid), .ack_priority(ack_priority), .provider_request(provider_request),
   .provider_winner(provider_winner));

/* bench/arb_model.sv */
// file: arbitration controller model on the far side of the node group
`timescale 1ns/10ps
module arb_model (
   input  wire logic            clk_sys,
   input  wire logic            rst,
   input  wire logic            ack_en,
   input  wire logic            hold_round,
   input  wire logic [3:0]      provider_request,
   input  wire logic [3:0][7:0] provider_winner,
   output logic      [3:0]      round_active,
   output logic      [3:0]      ack_valid,
   output logic      [7:0]      ack_priority
);
   logic [2:0] cool_r;
   int         sel;
   // ==========================================
   // round runs on command and during each acknowledge
   assign round_active = {4{hold_round}} | ack_valid;
   // acknowledge the winner of the lowest requesting provider, then rest
   always @(posedge clk_sys) begin
      sel = -1;
      for (int p = 3; p >= 0; p--) if (provider_request[p]) sel = p;
      ack_valid <= 4'h0;
      ack_priority <= ~ack_priority; // released qualifier keeps moving
      if (rst) begin
         cool_r <= 3'h0;
         ack_priority <= 8'h00;
      end else if (cool_r != 3'h0) begin
         cool_r <= cool_r - 3'h1;
      end else if (ack_en && sel >= 0) begin
         ack_valid <= 4'(1 << sel);
         ack_priority <= provider_winner[sel];
         cool_r <= 3'h6;
      end
   end
endmodule : arb_model

/* bench/test_request_node.sv */
// file: self-checking bench for the request node group
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; $display("wrong value %s exp %h got %h", n, e, g); end end
module test_request_node;
   import request_node_pkg::*;
   logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, source_trigger = 0, rmw_lock = 0;
   logic ack_en = 0, hold_round = 0, pready, pslverr, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, w, rng = 32'h0000_005A;
   logic [3:0] round_active, ack_valid, provider_request;
   logic [7:0] ack_priority, pr;
   logic [3:0][7:0] provider_winner;
   int err_total = 0, samples_checked = 0;
   // ==========================================
   always #4 clk_sys = ~clk_sys;
   request_node dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .source_trigger(source_trigger),
      .rmw_lock(rmw_lock), .round_active(round_active), .ack_valid(ack_valid), .ack_priority(ack_priority),
      .provider_request(provider_request), .provider_winner(provider_winner));
   arb_model partner (.clk_sys(clk_sys), .rst(rst), .ack_en(ack_en), .hold_round(hold_round),
      .provider_request(provider_request), .provider_winner(provider_winner), .round_active(round_active),
      .ack_valid(ack_valid), .ack_priority(ack_priority));
   function automatic logic [31:0] rand32();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : rand32
   // word as software should read it back
   function automatic logic [31:0] shown(input logic [31:0] v, input logic pend);
      return (v & 32'h0000_1CFF) | {18'h0, pend, 13'h0000};
   endfunction : shown
   task automatic wrap_up();
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   // one apb transfer; trig pulses the source at the edge that takes it
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic trig);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      rmw_lock <= wr;
      do begin
         @(posedge clk_sys);
         source_trigger <= (n == 0) ? trig : 1'b0;
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      rmw_lock <= 1'b0;
      if (n == 50) begin err_total++; wrap_up(); end
   endtask : apb
   task automatic wait_req(input int p, input logic want);
      int n;
      n = 0;
      while (provider_request[p] !== want && n < 40) begin @(posedge clk_sys); n++; end
      if (n == 40) begin err_total++; wrap_up(); end
   endtask : wait_req
   initial begin
      logic [1:0] code [5] = '{2'b10, 2'b11, 2'b01, 2'b11, 2'b10};
      logic       pend [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         apb(0, 12'(4 * i), 0, 0);
         `CHK("reset word", 32'h0000_0000, rd)
         w = rand32() & 32'hFFFF_3FFF;
         apb(1, 12'(4 * i), w, 0);
         apb(0, 12'(4 * i), 0, 0);
         `CHK("readback", shown(w, 1'b0), rd)
      end
      // strobe table: set, both, clear, both, set
      for (int k = 0; k < 5; k++) begin
         apb(1, 12'h008, {16'h0000, code[k], 14'h0000}, 0);
         apb(0, 12'h008, 0, 0);
         `CHK("strobes", shown(32'h0000_0000, pend[k]), rd)
      end
      apb(1, 12'h014, 32'h0000_80FF, 0);
      `CHK("unmapped err", 1'b1, er)
      apb(1, 12'h010, 32'h0000_0000, 1);
      apb(0, 12'h010, 0, 0);
      `CHK("software wins", 1'b0, rd[13])
      apb(0, 12'h010, 0, 1);
      apb(0, 12'h010, 0, 0);
      `CHK("trigger", 1'b1, rd[13])
      apb(0, 12'h000, 0, 0);
      `CHK("soft node", 1'b0, rd[13])
      apb(1, 12'h010, 32'h0000_4000, 1);
      apb(0, 12'h010, 0, 0);
      `CHK("clear wins", 1'b0, rd[13])
      for (int p = 0; p < 4; p++) begin
         w = rand32();
         pr = w[7:0] | 8'h01;
         apb(1, 12'h004, 32'h0000_9000 | 32'(p) << 10 | 32'(pr), 0);
         wait_req(p, 1);
         repeat (8) @(posedge clk_sys);
         `CHK("route", 4'b0001 << p, provider_request)
         `CHK("winner", pr, provider_winner[p])
         ack_en <= 1'b1;
         wait_req(p, 0);
         ack_en <= 1'b0;
         apb(0, 12'h004, 0, 0);
         `CHK("acked flag", 1'b0, rd[13])
      end
      apb(1, 12'h00C, 32'h0000_8055, 0);
      apb(1, 12'h008, 32'h0000_9000, 0);
      repeat (8) @(posedge clk_sys);
      `CHK("no request", 4'h0, provider_request)
      apb(0, 12'h00C, 0, 0);
      `CHK("flag while off", shown(32'h0000_0055, 1'b1), rd)
      apb(1, 12'h008, 32'h0000_4000, 0);
      hold_round <= 1'b1;
      apb(1, 12'h000, 32'h0000_9C22, 0); // even, node 1 keeps an odd priority
      repeat (6) @(posedge clk_sys);
      `CHK("held round", 4'h0, provider_request)
      hold_round <= 1'b0;
      wait_req(3, 1);
      `CHK("after round", 8'h22, provider_winner[3])
      apb(1, 12'h000, 32'h0000_4000, 0);
      wait_req(3, 0);
      wrap_up();
   end
endmodule : test_request_node
